// ===== logic/mlie_map.svh
`ifndef MLIE_MAP_SVH
`define MLIE_MAP_SVH

// opcode masks and match values, 14-bit words
`define MLIE_LB_MSK 14'h3FE0
`define MLIE_LB_VAL 14'h0020
`define MLIE_LP_MSK 14'h3F80
`define MLIE_LP_VAL 14'h3180
`define MLIE_LW_MSK 14'h3F00
`define MLIE_LW_VAL 14'h3000
`define MLIE_WF_MSK 14'h3F80
`define MLIE_WF_VAL 14'h0080
`define MLIE_WI_MSK 14'h3FF8
`define MLIE_WI_VAL 14'h0018
`define MLIE_WK_MSK 14'h3F80
`define MLIE_WK_VAL 14'h3F80
`define MLIE_NOP_VAL 14'h0000
`define MLIE_OPT_VAL 14'h0062
`define MLIE_RST_VAL 14'h0001
// file addresses of the two indirect windows
`define MLIE_WIN0 7'h00
`define MLIE_WIN1 7'h01
// register bus indices
`define MLIE_R_WORK 4'h0
`define MLIE_R_BANK 4'h1
`define MLIE_R_PCLH 4'h2
`define MLIE_R_OPT 4'h3
`define MLIE_R_P0L 4'h4
`define MLIE_R_P0H 4'h5
`define MLIE_R_P1L 4'h6
`define MLIE_R_P1H 4'h7
`define MLIE_R_POWER_CONTROL_REG 4'h8
`define MLIE_R_STAT 4'h9
// power control field position
`define MLIE_POWER_CONTROL_REG_SWR 2
// reset values
`define MLIE_RST_OPT 8'hFF
`define MLIE_RST_STAT 8'h00
`endif

// ===== logic/mlie_pkg.sv
package mlie_pkg;
  typedef enum logic [3:0] {
    MLIE_OP_NONE = 4'h0,
    MLIE_OP_LB = 4'h1,
    MLIE_OP_LP = 4'h2,
    MLIE_OP_LW = 4'h3,
    MLIE_OP_WF = 4'h4,
    MLIE_OP_WI = 4'h5,
    MLIE_OP_WK = 4'h6,
    MLIE_OP_NOP = 4'h7,
    MLIE_OP_OPT = 4'h8,
    MLIE_OP_RST = 4'h9,
    MLIE_OP_BAD = 4'hA
  } mlie_op_t;

  typedef enum logic [1:0] {
    MLIE_PRE_INC = 2'h0,
    MLIE_PRE_DEC = 2'h1,
    MLIE_POST_INC = 2'h2,
    MLIE_POST_DEC = 2'h3
  } mlie_mode_t;

  // write toward the data register file
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] data;
  } mlie_mem_wr_t;

  typedef struct packed {
    logic [7:0] work;
    logic [4:0] bank;
    logic [6:0] pclh;
    logic [7:0] opt;
    logic [1:0][15:0] ptr;
    logic swr_flag;
    logic [7:0] stat;
    logic [7:0] rdata;
    mlie_mem_wr_t mem;
    logic soft_rst;
  } mlie_state_t;
endpackage : mlie_pkg

// ===== logic/mlie_exec.sv
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`include "mlie_map.svh"
module mlie_exec #(
  parameter int REG_AW = 4
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // instruction from the fetch path
  input wire logic instr_valid_in,
  input wire logic [13:0] instr_in,
  output logic instr_done_out,
  output logic instr_bad_out,
  // register bus
  input wire logic [REG_AW-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // toward the register file and core
  output mlie_pkg::mlie_mem_wr_t mem_wr_out,
  output logic [4:0] bank_select_reg_out,
  output logic [6:0] pc_high_latch_out,
  output logic [7:0] option_reg_out,
  output logic soft_reset_out
);
  import mlie_pkg::*;

  // an index narrower than four bits cannot reach the whole map; refuse
  // it at elaboration rather than let registers alias one another
  if (REG_AW < 4) begin : g_aw_check
    $error("REG_AW must be at least 4");
  end

  mlie_state_t st_ff;
  mlie_state_t nxt_st;
  mlie_op_t op;
  logic [3:0] ra;
  logic [15:0] cur_ptr;
  logic [15:0] step_ptr;
  logic [15:0] rel_addr;
  logic sel;

  // an index past the map aliases nothing: it reads 00 and writes nowhere
  // upper address bits beyond the map make the access miss
  assign ra = (reg_addr_in >> 4) == '0 ? reg_addr_in[3:0] : 4'hF;

  // opcode classification; exact words are matched before masked groups
  // words of other groups fall through to the bad code and are ignored
  always_comb begin
    if (!instr_valid_in) begin
      op = MLIE_OP_NONE;
    end else if (instr_in == `MLIE_NOP_VAL) begin
      op = MLIE_OP_NOP;
    end else if (instr_in == `MLIE_RST_VAL) begin
      op = MLIE_OP_RST;
    end else if (instr_in == `MLIE_OPT_VAL) begin
      op = MLIE_OP_OPT;
    end else if ((instr_in & `MLIE_LB_MSK) == `MLIE_LB_VAL) begin
      op = MLIE_OP_LB;
    end else if ((instr_in & `MLIE_LP_MSK) == `MLIE_LP_VAL) begin
      op = MLIE_OP_LP;
    end else if ((instr_in & `MLIE_LW_MSK) == `MLIE_LW_VAL) begin
      op = MLIE_OP_LW;
    end else if ((instr_in & `MLIE_WF_MSK) == `MLIE_WF_VAL) begin
      op = MLIE_OP_WF;
    end else if ((instr_in & `MLIE_WI_MSK) == `MLIE_WI_VAL) begin
      op = MLIE_OP_WI;
    end else if ((instr_in & `MLIE_WK_MSK) == `MLIE_WK_VAL) begin
      op = MLIE_OP_WK;
    end else begin
      op = MLIE_OP_BAD;
    end
  end

  // pointer arithmetic; 16-bit sums wrap by width
  // each step direction has its own adder; bit 0 picks the direction, bit 1 the use
  always_comb begin
    sel = (op == MLIE_OP_WK) ? instr_in[6] : instr_in[2];
    cur_ptr = st_ff.ptr[sel];
    step_ptr = instr_in[0] ? cur_ptr - 16'h0001 : cur_ptr + 16'h0001;
    rel_addr = cur_ptr + {{10{instr_in[5]}}, instr_in[5:0]};
  end

  // next state: bus write first, a same-cycle instruction overrides it
  always_comb begin
    nxt_st = st_ff;
    nxt_st.mem.we = 1'b0;
    nxt_st.soft_rst = 1'b0;
    if (reg_wr_in) begin
      unique case (ra)
        `MLIE_R_WORK: nxt_st.work = reg_wdata_in;
        `MLIE_R_BANK: nxt_st.bank = reg_wdata_in[4:0];
        `MLIE_R_PCLH: nxt_st.pclh = reg_wdata_in[6:0];
        `MLIE_R_OPT: nxt_st.opt = reg_wdata_in;
        `MLIE_R_P0L: nxt_st.ptr[0][7:0] = reg_wdata_in;
        `MLIE_R_P0H: nxt_st.ptr[0][15:8] = reg_wdata_in;
        `MLIE_R_P1L: nxt_st.ptr[1][7:0] = reg_wdata_in;
        `MLIE_R_P1H: nxt_st.ptr[1][15:8] = reg_wdata_in;
        `MLIE_R_POWER_CONTROL_REG: nxt_st.swr_flag = reg_wdata_in[`MLIE_POWER_CONTROL_REG_SWR];
        `MLIE_R_STAT: nxt_st.stat = reg_wdata_in;
        default: nxt_st.swr_flag = st_ff.swr_flag;
      endcase
    end
    // only the soft reset instruction of this group touches stat
    unique case (op)
      MLIE_OP_LB: nxt_st.bank = instr_in[4:0];
      MLIE_OP_LP: nxt_st.pclh = instr_in[6:0];
      MLIE_OP_LW: nxt_st.work = instr_in[7:0];
      MLIE_OP_WF: begin
        nxt_st.mem.we = 1'b1;
        nxt_st.mem.data = st_ff.work;
        // windows have no storage, aim at the pointer instead
        if (instr_in[6:0] == `MLIE_WIN0) begin
          nxt_st.mem.addr = st_ff.ptr[0];
        end else if (instr_in[6:0] == `MLIE_WIN1) begin
          nxt_st.mem.addr = st_ff.ptr[1];
        end else begin
          nxt_st.mem.addr = {4'h0, st_ff.bank, instr_in[6:0]};
        end
      end
      MLIE_OP_WI: begin
        nxt_st.mem.we = 1'b1;
        nxt_st.mem.data = st_ff.work;
        // bit 1 picks post, bit 0 picks decrement
        nxt_st.mem.addr = instr_in[1] ? cur_ptr : step_ptr;
        nxt_st.ptr[sel] = step_ptr;
      end
      MLIE_OP_WK: begin
        nxt_st.mem.we = 1'b1;
        nxt_st.mem.data = st_ff.work;
        nxt_st.mem.addr = rel_addr; // pointer kept
      end
      MLIE_OP_OPT: nxt_st.opt = st_ff.work;
      MLIE_OP_RST: begin
        // same values as the hardware reset, flag cleared
        nxt_st = '0;
        nxt_st.opt = `MLIE_RST_OPT;
        nxt_st.stat = `MLIE_RST_STAT;
        nxt_st.swr_flag = 1'b0;
        nxt_st.soft_rst = 1'b1;
      end
      MLIE_OP_NOP: nxt_st.mem.we = 1'b0; // nothing changes
      MLIE_OP_NONE, MLIE_OP_BAD: nxt_st.mem.we = 1'b0;
    endcase
    // read data is shown one cycle after the strobe and only then
    nxt_st.rdata = 8'h00;
    if (reg_rd_in) begin
      unique case (ra)
        `MLIE_R_WORK: nxt_st.rdata = st_ff.work;
        `MLIE_R_BANK: nxt_st.rdata = {3'h0, st_ff.bank};
        `MLIE_R_PCLH: nxt_st.rdata = {1'h0, st_ff.pclh};
        `MLIE_R_OPT: nxt_st.rdata = st_ff.opt;
        `MLIE_R_P0L: nxt_st.rdata = st_ff.ptr[0][7:0];
        `MLIE_R_P0H: nxt_st.rdata = st_ff.ptr[0][15:8];
        `MLIE_R_P1L: nxt_st.rdata = st_ff.ptr[1][7:0];
        `MLIE_R_P1H: nxt_st.rdata = st_ff.ptr[1][15:8];
        `MLIE_R_POWER_CONTROL_REG: nxt_st.rdata = 8'(st_ff.swr_flag) << `MLIE_POWER_CONTROL_REG_SWR;
        `MLIE_R_STAT: nxt_st.rdata = st_ff.stat;
        default: nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // single state register; hardware reset sets the flag
  // the flag lets software tell a power-up from a software reset
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
      st_ff.opt <= `MLIE_RST_OPT;
      st_ff.stat <= `MLIE_RST_STAT;
      st_ff.swr_flag <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // every accepted word retires in its own cycle
  assign instr_done_out = instr_valid_in && op != MLIE_OP_BAD;
  assign instr_bad_out = op == MLIE_OP_BAD;
  assign reg_rdata_out = st_ff.rdata;
  assign mem_wr_out = st_ff.mem;
  assign bank_select_reg_out = st_ff.bank;
  assign pc_high_latch_out = st_ff.pclh;
  assign option_reg_out = st_ff.opt;
  assign soft_reset_out = st_ff.soft_rst;

  // checks follow the core clock and pause while reset is held
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  bank_load_a: assert property (op == MLIE_OP_LB |=>
    bank_select_reg_out == $past(instr_in[4:0]))
    else $error("bank load wrong");
  page_load_a: assert property (op == MLIE_OP_LP |=>
    pc_high_latch_out == $past(instr_in[6:0]))
    else $error("page latch load wrong");
  work_load_a: assert property (op == MLIE_OP_LW ##1
    reg_rd_in && reg_addr_in == REG_AW'(`MLIE_R_WORK) |=>
    reg_rdata_out == $past(instr_in[7:0], 2))
    else $error("working load wrong");
  file_store_a: assert property (op == MLIE_OP_WF &&
    instr_in[6:1] != 6'h00 |=> mem_wr_out.we &&
    mem_wr_out.addr == {4'h0, $past(st_ff.bank), $past(instr_in[6:0])} &&
    mem_wr_out.data == $past(st_ff.work))
    else $error("file store wrong");
  window_redir_a: assert property (op == MLIE_OP_WF &&
    instr_in[6:0] == `MLIE_WIN1 |=> mem_wr_out.addr == $past(st_ff.ptr[1]))
    else $error("window not redirected");
  pre_inc_a: assert property (op == MLIE_OP_WI &&
    instr_in[1:0] == 2'h0 && !instr_in[2] |=>
    mem_wr_out.addr == 16'($past(st_ff.ptr[0]) + 16'h0001) &&
    st_ff.ptr[0] == mem_wr_out.addr)
    else $error("pre-increment wrong");
  post_dec_a: assert property (op == MLIE_OP_WI &&
    instr_in[1:0] == 2'h3 && instr_in[2] |=>
    mem_wr_out.addr == $past(st_ff.ptr[1]) &&
    st_ff.ptr[1] == 16'($past(st_ff.ptr[1]) - 16'h0001))
    else $error("post-decrement wrong");
  rel_addr_a: assert property (op == MLIE_OP_WK && !reg_wr_in |=>
    mem_wr_out.addr == 16'($past(cur_ptr) +
    {{10{$past(instr_in[5])}}, $past(instr_in[5:0])}) &&
    $stable(st_ff.ptr))
    else $error("relative store wrong");
  ptr_wrap_a: assert property (op == MLIE_OP_WI &&
    instr_in[1:0] == 2'h0 && cur_ptr == 16'hFFFF |=>
    mem_wr_out.addr == 16'h0000)
    else $error("pointer did not wrap");
  stat_keep_a: assert property (op != MLIE_OP_RST &&
    !(reg_wr_in && ra == `MLIE_R_STAT) |=> $stable(st_ff.stat))
    else $error("status changed");
  opt_load_a: assert property (op == MLIE_OP_OPT |=>
    option_reg_out == $past(st_ff.work))
    else $error("option load wrong");
  soft_rst_a: assert property (op == MLIE_OP_RST |=>
    soft_reset_out && st_ff.work == 8'h00 && st_ff.bank == 5'h00 &&
    st_ff.pclh == 7'h00 && st_ff.ptr == '0 &&
    st_ff.opt == `MLIE_RST_OPT && !mem_wr_out.we)
    else $error("soft reset wrong");
  swr_clear_a: assert property (op == MLIE_OP_RST |=>
    !st_ff.swr_flag ##1 ($past(reg_wr_in) || !st_ff.swr_flag))
    else $error("reset flag not cleared");
  nop_keep_a: assert property (op == MLIE_OP_NOP && !reg_wr_in |=>
    $stable(st_ff.work) && $stable(st_ff.ptr) && !mem_wr_out.we)
    else $error("no-op changed state");
  one_cycle_a: assert property (instr_valid_in &&
    op != MLIE_OP_BAD |-> instr_done_out && !instr_bad_out ##1
    mem_wr_out.we == $past(op inside {MLIE_OP_WF, MLIE_OP_WI, MLIE_OP_WK}))
    else $error("instruction not retired");

  // the two remaining pointer modes, on whichever pointer the word names
  pre_dec_a: assert property (op == MLIE_OP_WI &&
    instr_in[1:0] == 2'h1 |=>
    mem_wr_out.addr == 16'($past(cur_ptr) - 16'h0001) &&
    mem_wr_out.data == $past(st_ff.work))
    else $error("pre-decrement wrong");
  post_inc_a: assert property (op == MLIE_OP_WI &&
    instr_in[1:0] == 2'h2 |=> mem_wr_out.addr == $past(cur_ptr) &&
    st_ff.ptr[$past(sel)] == 16'($past(cur_ptr) + 16'h0001))
    else $error("post-increment wrong");
  wrap_down_a: assert property (op == MLIE_OP_WI &&
    instr_in[1:0] == 2'h1 && cur_ptr == 16'h0000 |=>
    mem_wr_out.addr == 16'hFFFF && st_ff.ptr[$past(sel)] == 16'hFFFF)
    else $error("pointer did not wrap down");
  // the pointer that the word does not name must not move
  other_ptr_a: assert property (op == MLIE_OP_WI &&
    !reg_wr_in |=> st_ff.ptr[!$past(sel)] == $past(st_ff.ptr[!sel]))
    else $error("wrong pointer stepped");
  win0_redir_a: assert property (op == MLIE_OP_WF &&
    instr_in[6:0] == `MLIE_WIN0 |=> mem_wr_out.addr == $past(st_ff.ptr[0]))
    else $error("window 0 not redirected");
  rel_data_a: assert property (op == MLIE_OP_WK |=>
    mem_wr_out.we && mem_wr_out.data == $past(st_ff.work))
    else $error("relative store data wrong");
  file_ptr_keep_a: assert property (op == MLIE_OP_WF &&
    !reg_wr_in |=> $stable(st_ff.ptr))
    else $error("direct store moved a pointer");
  // a word outside the group must leave work and the pointers alone and store nothing
  bad_word_a: assert property (op == MLIE_OP_BAD &&
    !reg_wr_in |-> instr_bad_out && !instr_done_out ##1
    $stable(st_ff.work) && $stable(st_ff.ptr) && !mem_wr_out.we &&
    !soft_reset_out)
    else $error("foreign word took effect");
  // the core is released after exactly one cycle of soft reset
  srst_pulse_a: assert property (op == MLIE_OP_RST ##1
    op != MLIE_OP_RST |=> !soft_reset_out)
    else $error("soft reset pulse too long");
  // literal loads and the option load never reach the data file
  lit_no_store_a: assert property (op inside {MLIE_OP_LB,
    MLIE_OP_LP, MLIE_OP_LW, MLIE_OP_OPT} |=> !mem_wr_out.we)
    else $error("literal load wrote the file");
  // read data live one cycle only, so a stale byte is never read twice
  rdata_idle_a: assert property (!reg_rd_in |=>
    reg_rdata_out == 8'h00)
    else $error("read data stood too long");

  // main scenarios worth seeing at least once
  ind_store_c: cover property (op == MLIE_OP_WI ##1 op == MLIE_OP_WI);
  rel_store_c: cover property (op == MLIE_OP_WK && instr_in[5]);
  soft_rst_c: cover property (op == MLIE_OP_RST);
  win_store_c: cover property (op == MLIE_OP_WF && instr_in[6:1] == 6'h00);
  bad_word_c: cover property (op == MLIE_OP_BAD);
endmodule : mlie_exec

// ===== bench/mlie_rf_model.sv
`timescale 1ns/100ps
module mlie_rf_model
  import mlie_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // writes coming from the executer
  input mlie_pkg::mlie_mem_wr_t mem_wr_in,
  // what the file has seen
  output logic [15:0] last_addr_out,
  output logic [7:0] last_data_out,
  output logic [7:0] wr_cnt_out
);
  // behavioural data file: keeps only the last write and a count, so the
  // bench can prove that a word wrote nothing without a full memory
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wr_cnt_out <= 8'h00;
      last_addr_out <= 16'h0000;
      last_data_out <= 8'h00;
    end else if (mem_wr_in.we) begin
      wr_cnt_out <= wr_cnt_out + 8'h01;
      last_addr_out <= mem_wr_in.addr;
      last_data_out <= mem_wr_in.data;
    end
  end
endmodule : mlie_rf_model

// ===== bench/move_literal_instr_exec_tb_top.sv
`timescale 1ns/100ps
module move_literal_instr_exec_tb_top;
  import mlie_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic iv = 1'b0;
  logic [13:0] iw = 14'h0000;
  logic [4:0] ra = 5'h00;
  logic [7:0] rwd = 8'h00;
  logic rwr = 1'b0;
  logic rrd = 1'b0;
  logic done, bad, srst;
  logic [7:0] rdat, optr, ld, wc, v, h;
  logic [4:0] bank_q;
  logic [6:0] pcl;
  logic [15:0] la, b, np, ea;
  mlie_mem_wr_t mw;
  int n_fail = 0;
  int tests_run = 0;

  // 20 MHz core clock
  always #25 ref_clk = ~ref_clk;

  mlie_exec #(.REG_AW(5)) dut_u (.ref_clk_in(ref_clk), .rst_n_in(rst_n),
    .instr_valid_in(iv), .instr_in(iw), .instr_done_out(done),
    .instr_bad_out(bad), .reg_addr_in(ra), .reg_wdata_in(rwd),
    .reg_wr_in(rwr), .reg_rd_in(rrd), .reg_rdata_out(rdat),
    .mem_wr_out(mw), .bank_select_reg_out(bank_q),
    .pc_high_latch_out(pcl), .option_reg_out(optr), .soft_reset_out(srst));

  mlie_rf_model rf_u (.ref_clk_in(ref_clk), .rst_n_in(rst_n),
    .mem_wr_in(mw), .last_addr_out(la), .last_data_out(ld),
    .wr_cnt_out(wc));

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask : chk

  // one-cycle write strobe, master moves just after the edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    ra <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge ref_clk);
    rwr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    ra <= a;
    rrd <= 1'b1;
    @(posedge ref_clk);
    rrd <= 1'b0;
    #1 d = rdat;
  endtask : rd

  // one word, one cycle; returns just after the taking edge
  task automatic ex(input logic [13:0] w, input logic is_bad);
    @(posedge ref_clk);
    iv <= 1'b1;
    iw <= w;
    #1 chk("done", !is_bad, done);
    chk("bad", is_bad, bad);
    @(posedge ref_clk);
    iv <= 1'b0;
    #1;
  endtask : ex

  task automatic setp(input int n, input logic [15:0] p);
    wr(5'(4 + 2 * n), p[7:0]);
    wr(5'(5 + 2 * n), p[15:8]);
  endtask : setp

  task automatic getp(input int n, output logic [15:0] p);
    rd(5'(4 + 2 * n), p[7:0]);
    rd(5'(5 + 2 * n), p[15:8]);
  endtask : getp

  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_fail++;
    test_done;
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(5'h03, v); chk("opt_rst", 16'h00FF, v);
    rd(5'h08, v); chk("swr_flag", 16'h0001, v[2]);
    wr(5'h10, 8'h77); rd(5'h10, v); chk("unmapped", 16'h0000, v);
    rd(5'h00, v); chk("unmapped_wr", 16'h0000, v);
    wr(5'h09, 8'h3C);
    ex(14'h003F, 1'b0); chk("bank", 16'h001F, bank_q);
    ex(14'h31FF, 1'b0); chk("pclh", 16'h007F, pcl);
    // literal load followed at once by a read of the working register
    @(posedge ref_clk);
    iv <= 1'b1;
    iw <= 14'h305A;
    @(posedge ref_clk);
    iv <= 1'b0;
    ra <= 5'h00;
    rrd <= 1'b1;
    @(posedge ref_clk);
    rrd <= 1'b0;
    #1 chk("work_b2b", 16'h005A, rdat);
    @(posedge ref_clk);
    #1 chk("rdata_idle", 16'h0000, rdat);
    ex(14'h30A5, 1'b0); rd(5'h00, v); chk("work", 16'h00A5, v);
    ex(14'h0085, 1'b0); chk("we", 16'h0001, mw.we);
    chk("addr", 16'h0F85, mw.addr);
    chk("data", 16'h00A5, mw.data);
    setp(0, 16'h1234);
    ex(14'h0080, 1'b0); chk("win_addr", 16'h1234, mw.addr);
    // every mode, each from the value that makes it wrap
    for (int m = 0; m < 4; m++) begin
      b = (m % 2 == 0) ? 16'hFFFF : 16'h0000;
      np = (m % 2 == 1) ? b - 16'h0001 : b + 16'h0001;
      ea = (m >= 2) ? b : np;
      setp(m / 2, b);
      ex(14'h3060 | 14'(m), 1'b0);
      ex(14'h0018 | 14'((m / 2) * 4 + m), 1'b0);
      chk("ind_addr", ea, mw.addr);
      getp(m / 2, b); chk("ind_ptr", np, b);
      chk("ind_data", 16'(8'h60 + m), ld);
      chk("ind_file", ea, la);
    end
    ex(14'h30A5, 1'b0);
    setp(0, 16'h0010);
    ex(14'h3FA0, 1'b0); chk("rel_lo", 16'hFFF0, mw.addr);
    getp(0, b); chk("rel_ptr0", 16'h0010, b);
    setp(1, 16'h1000);
    ex(14'h3FDF, 1'b0); chk("rel_hi", 16'h101F, mw.addr);
    getp(1, b); chk("rel_ptr1", 16'h1000, b);
    ex(14'h0081, 1'b0); chk("win1_addr", 16'h1000, mw.addr);
    ex(14'h0062, 1'b0); chk("opt", 16'h00A5, optr);
    h = wc;
    ex(14'h0000, 1'b0); chk("nop_we", 16'h0000, mw.we);
    ex(14'h0002, 1'b1);
    rd(5'h00, v); chk("work_kept", 16'h00A5, v);
    chk("wr_cnt", h, wc);
    rd(5'h09, v); chk("stat", 16'h003C, v);
    ex(14'h0001, 1'b0); chk("srst", 16'h0001, srst);
    @(posedge ref_clk);
    #1 chk("srst_end", 16'h0000, srst);
    chk("bank_rst", 16'h0000, bank_q);
    rd(5'h00, v); chk("work_rst", 16'h0000, v);
    rd(5'h03, v); chk("opt_rst2", 16'h00FF, v);
    rd(5'h08, v); chk("swr_clr", 16'h0000, v[2]);
    chk("pclh_rst", 16'h0000, pcl);
    getp(0, b); chk("ptr_rst", 16'h0000, b);
    rd(5'h09, v); chk("stat_rst", 16'h0000, v);
    test_done;
  end
endmodule : move_literal_instr_exec_tb_top
